/* File: gpio_ports.sv */
// General-purpose I/O port block with APB register access
`timescale 1ns/1ps
// Functional notes
// - Thirteen bidirectional ports and two input-only ports; pins take alternate functions.
// - Per-port direction register chooses output or input for each pin.
// - Per-port output latch holds written value and drives output pins.
// - Pin-state register reads back the sampled pin levels of each port.
// - Input-only ports 4 and 9 have pin read only, no latch or direction.
// - Ports A to E carry per-pin pull-up enable bits.
// - Ports 3 and A to C carry open-drain bits disabling the high side.
// - Pins shared by mode; port A gives address outputs in modes 4 to 6.
module gpio_ports (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Bidirectional port pins
  input wire logic [gpio_pkg::BIDIR_W-1:0] pin_in,
  output logic [gpio_pkg::BIDIR_W-1:0] pin_out,
  output logic [gpio_pkg::BIDIR_W-1:0] pin_oe,
  output logic [gpio_pkg::PULL_W-1:0] pullup_en,
  // Input-only port pins
  input wire logic [gpio_pkg::IN_W-1:0] inonly_in,
  // Alternate function overrides per bidirectional pin
  input wire logic [gpio_pkg::BIDIR_W-1:0] alt_sel,
  input wire logic [gpio_pkg::BIDIR_W-1:0] alt_out,
  input wire logic [gpio_pkg::BIDIR_W-1:0] alt_oe,
  // Upper address from the bus controller
  input wire logic [gpio_pkg::PW-1:0] addr_upper,
  // Current operating mode
  output logic [2:0] op_mode
);
  typedef struct packed {
    logic [gpio_pkg::BIDIR_W-1:0] dir;
    logic [gpio_pkg::BIDIR_W-1:0] latch;
    logic [gpio_pkg::PULL_W-1:0] pull;
    logic [gpio_pkg::OD_W-1:0] od;
    logic [2:0] mode;
    logic [31:0] rdata;
    logic err;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;
  logic [gpio_pkg::SYNC_W-1:0] pins_q;
  logic [2:0] rgn;
  logic [3:0] idx;
  logic setup;
  logic wr;
  logic bus_mode;

  // Open-drain slot to bidirectional port slot
  function automatic int od_port(input int k);
    return (k == 0) ? gpio_pkg::PORT_3 : gpio_pkg::PORT_A + k - 1;
  endfunction : od_port

  // Whether a region and index name an implemented register
  function automatic logic reg_ok(input logic [2:0] r, input logic [3:0] i);
    unique case (r)
      gpio_pkg::RGN_DIR: return int'(i) < gpio_pkg::NBIDIR;
      gpio_pkg::RGN_LATCH: return int'(i) < gpio_pkg::NBIDIR;
      gpio_pkg::RGN_PIN: return int'(i) < gpio_pkg::NPIN_PORTS;
      gpio_pkg::RGN_PULL: return int'(i) < gpio_pkg::NPULL;
      gpio_pkg::RGN_OD: return int'(i) < gpio_pkg::NOD;
      gpio_pkg::RGN_MODE: return i == 4'h0;
      default: return 1'b0;
    endcase
  endfunction : reg_ok

  gpio_pin_sync #(
    .W(gpio_pkg::SYNC_W)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .raw({inonly_in, pin_in}),
    .level(pins_q)
  );

  assign rgn = paddr[gpio_pkg::RGN_LSB +: 3];
  assign idx = paddr[gpio_pkg::IDX_LSB +: 4];
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && !s.err && pstrb[0];

  always_comb begin
    next_s = s;
    if (setup) begin
      next_s.rdata = '0;
      next_s.err = !reg_ok(rgn, idx);
      unique case (rgn)
        gpio_pkg::RGN_DIR: if (reg_ok(rgn, idx)) begin
          next_s.rdata[7:0] = s.dir[int'(idx) * gpio_pkg::PW +: 8];
        end
        gpio_pkg::RGN_LATCH: if (reg_ok(rgn, idx)) begin
          next_s.rdata[7:0] = s.latch[int'(idx) * gpio_pkg::PW +: 8];
        end
        gpio_pkg::RGN_PIN: if (reg_ok(rgn, idx)) begin
          next_s.rdata[7:0] = pins_q[int'(idx) * gpio_pkg::PW +: 8];
        end
        gpio_pkg::RGN_PULL: if (reg_ok(rgn, idx)) begin
          next_s.rdata[7:0] = s.pull[int'(idx) * gpio_pkg::PW +: 8];
        end
        gpio_pkg::RGN_OD: if (reg_ok(rgn, idx)) begin
          next_s.rdata[7:0] = s.od[int'(idx) * gpio_pkg::PW +: 8];
        end
        gpio_pkg::RGN_MODE: if (reg_ok(rgn, idx)) begin
          next_s.rdata[2:0] = s.mode;
        end
        default: next_s.rdata = '0;
      endcase
    end
    // Writes land at the access edge; pin region is read-only
    if (wr) begin
      unique case (rgn)
        gpio_pkg::RGN_DIR: begin
          next_s.dir[int'(idx) * gpio_pkg::PW +: 8] = pwdata[7:0];
        end
        gpio_pkg::RGN_LATCH: begin
          next_s.latch[int'(idx) * gpio_pkg::PW +: 8] = pwdata[7:0];
        end
        gpio_pkg::RGN_PULL: begin
          next_s.pull[int'(idx) * gpio_pkg::PW +: 8] = pwdata[7:0];
        end
        gpio_pkg::RGN_OD: begin
          next_s.od[int'(idx) * gpio_pkg::PW +: 8] = pwdata[7:0];
        end
        gpio_pkg::RGN_MODE: begin
          next_s.mode = pwdata[2:0];
        end
        default: next_s.err = s.err;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s.dir <= '0;
      s.latch <= '0;
      s.pull <= '0;
      s.od <= '0;
      s.mode <= gpio_pkg::MODE_RESET;
      s.rdata <= '0;
      s.err <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && s.err;
  assign op_mode = s.mode;
  assign bus_mode = (s.mode >= gpio_pkg::MODE_BUS_FIRST) &&
                    (s.mode <= gpio_pkg::MODE_BUS_LAST);

  // Pin drivers: bus address first, then alternate function, then port
  always_comb begin
    logic od_bit;
    int p;
    od_bit = 1'b0;
    p = 0;
    for (int i = 0; i < gpio_pkg::BIDIR_W; i++) begin
      p = i / gpio_pkg::PW;
      od_bit = 1'b0;
      for (int k = 0; k < gpio_pkg::NOD; k++) begin
        if (od_port(k) == p) begin
          od_bit = s.od[k * gpio_pkg::PW + i % gpio_pkg::PW];
        end
      end
      if (bus_mode && p == gpio_pkg::PORT_A) begin
        pin_out[i] = addr_upper[i % gpio_pkg::PW];
        pin_oe[i] = 1'b1;
      end else if (alt_sel[i]) begin
        pin_out[i] = alt_out[i];
        pin_oe[i] = alt_oe[i] && !(od_bit && alt_out[i]);
      end else begin
        pin_out[i] = s.latch[i];
        // Open drain drives low only; high side left off
        pin_oe[i] = s.dir[i] && !(od_bit && s.latch[i]);
      end
    end
  end

  // Pull-ups act only on pins the port treats as inputs
  always_comb begin
    for (int i = 0; i < gpio_pkg::PULL_W; i++) begin
      pullup_en[i] = s.pull[i] &&
        !s.dir[gpio_pkg::PORT_A * gpio_pkg::PW + i];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_DIR_WRITE: assert property (
    wr && rgn == gpio_pkg::RGN_DIR && idx == 4'h0 && !alt_sel[0]
    |=> pin_oe[0] == $past(pwdata[0]))
    else $error("direction write did not steer pin enable");
  AST_LATCH_DRIVE: assert property (
    wr && rgn == gpio_pkg::RGN_LATCH && idx == 4'h1 && !alt_sel[8]
    |=> pin_out[15:8] == $past(pwdata[7:0]))
    else $error("latch write did not reach pins");
  AST_PIN_READ: assert property (
    setup && rgn == gpio_pkg::RGN_PIN && idx == 4'h0
    |=> prdata[7:0] == $past(pins_q[7:0]) && prdata[31:8] == '0)
    else $error("pin read returned wrong level");
  AST_INONLY_NO_DIR: assert property (
    setup && rgn == gpio_pkg::RGN_DIR && idx == 4'hD
    |=> penable |-> pslverr)
    else $error("input-only port accepted a direction access");
  AST_PULLUP: assert property (
    wr && rgn == gpio_pkg::RGN_PULL && idx == 4'h0
    |=> pullup_en[7:0] == ($past(pwdata[7:0]) & ~s.dir[39:32]))
    else $error("pull-up write not applied to port A");
  AST_OPEN_DRAIN: assert property (
    s.od[0] && s.latch[16] && !alt_sel[16] |-> !pin_oe[16])
    else $error("open-drain pin drove high");
  AST_BUS_MODE: assert property (
    wr && rgn == gpio_pkg::RGN_MODE && pwdata[2:0] == 3'h4
    |=> ##1 pin_oe[39:32] == 8'hFF && pin_out[39:32] == addr_upper)
    else $error("port A not carrying address in bus mode");
  AST_RESET_STATE: assert property (
    $rose(rstn) |-> s.dir == '0 && pullup_en == '0 && s.od == '0)
    else $error("port controls not cleared by reset");
  AST_ALT_FUNC: assert property (
    alt_sel[0] |-> pin_out[0] == alt_out[0])
    else $error("alternate function not routed");

  // Register bus checks
  AST_STRB_IGNORED: assert property (
    psel && penable && pwrite && !pstrb[0]
    |=> $stable(s.dir) && $stable(s.latch) && $stable(s.mode))
    else $error("write with low strobe changed a register");
  AST_DIR_HOLD: assert property (
    !wr |=> $stable(s.dir))
    else $error("direction changed without a write");
  AST_LATCH_HOLD: assert property (
    !wr |=> $stable(s.latch))
    else $error("output latch changed without a write");
  AST_PIN_NO_WRITE: assert property (
    wr && rgn == gpio_pkg::RGN_PIN
    |=> $stable(s.dir) && $stable(s.latch) && $stable(s.pull))
    else $error("write to pin region changed a register");
  AST_READ_WIDTH: assert property (
    psel && penable |-> pready && prdata[31:8] == '0)
    else $error("read data carried bits above the port byte");
  AST_INONLY_P4_READ: assert property (
    setup && rgn == gpio_pkg::RGN_PIN && idx == 4'hD
    |=> prdata[7:0] == $past(pins_q[111:104]))
    else $error("port 4 read returned wrong level");
  AST_INONLY_P9_READ: assert property (
    setup && rgn == gpio_pkg::RGN_PIN && idx == 4'hE
    |=> prdata[7:0] == $past(pins_q[119:112]))
    else $error("port 9 read returned wrong level");
  AST_ERR_NO_WRITE: assert property (
    pslverr |=> $stable(s.dir) && $stable(s.latch) && $stable(s.pull) &&
    $stable(s.od) && $stable(s.mode))
    else $error("refused access changed a register");
  AST_ERR_READ_ZERO: assert property (
    setup && !reg_ok(rgn, idx) |=> prdata == '0)
    else $error("refused read returned data");

  // Pin driver checks
  AST_ALT_ENABLE: assert property (
    alt_sel[0] |-> pin_oe[0] == alt_oe[0])
    else $error("alternate function enable not routed");
  AST_DIR_INPUT: assert property (
    !s.dir[0] && !alt_sel[0] |-> !pin_oe[0])
    else $error("input pin was driven");
  AST_PULL_INPUT_ONLY: assert property (
    s.dir[32] |-> !pullup_en[0])
    else $error("pull-up left on at an output pin");
  AST_OD_ALT: assert property (
    alt_sel[16] && alt_out[16] && s.od[0] |-> !pin_oe[16])
    else $error("open-drain alternate output drove high");
  AST_OD_PORT_A: assert property (
    s.od[8] && s.latch[32] && !alt_sel[32] && !bus_mode
    |-> !pin_oe[32])
    else $error("open-drain port A pin drove high");
  AST_BUS_PRIORITY: assert property (
    bus_mode |-> pin_oe[39:32] == 8'hFF &&
    pin_out[39:32] == addr_upper)
    else $error("bus mode lost port A address drive");
  AST_PORT_MODE: assert property (
    !bus_mode && !alt_sel[32] |-> pin_out[32] == s.latch[32])
    else $error("port A pin not driven from its latch");

  // Reset checks
  AST_RESET_MODE: assert property (
    $rose(rstn) |-> op_mode == gpio_pkg::MODE_RESET && prdata == '0)
    else $error("mode or read data not reset");

  COV_DIR_WRITE: cover property (wr && rgn == gpio_pkg::RGN_DIR);
  COV_PIN_READ: cover property (setup && !pwrite && rgn == gpio_pkg::RGN_PIN);
  COV_BUS_MODE: cover property (bus_mode);
  COV_OPEN_DRAIN: cover property (s.od != '0 && s.dir[23:16] != '0);
  COV_ALT_FUNC: cover property (alt_sel[0] && alt_oe[0]);
endmodule : gpio_ports

/* File: gpio_pkg.sv */
// Shared constants for the general-purpose port block
package gpio_pkg;
  localparam int NBIDIR = 13;
  localparam int NINONLY = 2;
  localparam int PW = 8;
  localparam int BIDIR_W = NBIDIR * PW;
  localparam int IN_W = NINONLY * PW;
  localparam int SYNC_W = BIDIR_W + IN_W;
  localparam int NPULL = 5;
  localparam int PULL_W = NPULL * PW;
  localparam int NOD = 4;
  localparam int OD_W = NOD * PW;
  // Bidirectional port slots: 0 P1, 1 P2, 2 P3, 3 P5, 4 PA, 5 PB, 6 PC,
  // 7 PD, 8 PE, 9 PF, 10 PH, 11 PJ, 12 PK; pin slots 13 P4, 14 P9
  localparam int PORT_3 = 2;
  localparam int PORT_A = 4;
  localparam int NPIN_PORTS = NBIDIR + NINONLY;
  // Address layout: region in paddr[8:6], port index in paddr[5:2]
  localparam int ADDR_W = 12;
  localparam int RGN_LSB = 6;
  localparam int IDX_LSB = 2;
  localparam logic [2:0] RGN_DIR = 3'h0;
  localparam logic [2:0] RGN_LATCH = 3'h1;
  localparam logic [2:0] RGN_PIN = 3'h2;
  localparam logic [2:0] RGN_PULL = 3'h3;
  localparam logic [2:0] RGN_OD = 3'h4;
  localparam logic [2:0] RGN_MODE = 3'h5;
  // Operating modes
  localparam logic [2:0] MODE_RESET = 3'h7;
  localparam logic [2:0] MODE_BUS_FIRST = 3'h4;
  localparam logic [2:0] MODE_BUS_LAST = 3'h6;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage : gpio_pkg

/* File: gpio_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gpio_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Pins in, filtered levels out
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.s1 = raw;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    // A bit changes only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.level[i] = s.s3[i];
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;
endmodule : gpio_pin_sync

/* File: gpio_pin_model.sv */
// Board-side model of the port pins: loads, pull-ups, floating lines
`timescale 1ns/1ps
module gpio_pin_model (
  // Clock
  input wire logic clock,
  // Pin side of the port block
  input wire logic [gpio_pkg::BIDIR_W-1:0] pin_out,
  input wire logic [gpio_pkg::BIDIR_W-1:0] pin_oe,
  input wire logic [gpio_pkg::PULL_W-1:0] pullup_en,
  output logic [gpio_pkg::BIDIR_W-1:0] pin_in
);
  logic toggle = 1'b0;
  logic [gpio_pkg::BIDIR_W-1:0] pull_full;
  always @(posedge clock) begin
    toggle <= ~toggle;
  end
  // Undriven, unpulled lines toggle every clock, so the synchroniser keeps their last agreed level
  always_comb begin
    pull_full = '0;
    pull_full[gpio_pkg::PORT_A*gpio_pkg::PW +: gpio_pkg::PULL_W] = pullup_en;
    for (int i = 0; i < gpio_pkg::BIDIR_W; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (pull_full[i]) pin_in[i] = 1'b1;
      else pin_in[i] = toggle ^ i[0];
    end
  end
endmodule : gpio_pin_model

/* File: general_purpose_io_ports_test.sv */
// Self-checking testbench for the port block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module general_purpose_io_ports_test;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, rerr;
  logic [gpio_pkg::BIDIR_W-1:0] pin_in, pin_out, pin_oe;
  logic [gpio_pkg::BIDIR_W-1:0] alt_sel = '0, alt_out = '0, alt_oe = '0;
  logic [39:0] pullup_en;
  logic [15:0] inonly_in = 16'h0000;
  logic [7:0] addr_upper = 8'hC3, rdat;
  logic [2:0] op_mode;
  int n_errors = 0, comparisons = 0, cycles = 0;
  // Rows: address, write data, expected read back
  logic [27:0] rows[7] = '{28'h000A5A5, 28'h0403C3C, 28'h0449696,
    28'h0C00F0F, 28'h1008181, 28'h030FFFF, 28'h140FD05};
  gpio_ports u_dut (.clock(clock), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .inonly_in(inonly_in), .alt_sel(alt_sel),
    .alt_out(alt_out), .alt_oe(alt_oe), .addr_upper(addr_upper),
    .op_mode(op_mode));
  gpio_pin_model u_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .pin_in(pin_in));
  always #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata[7:0];
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task done(input string s);
    $display("test %s done", s);
  endtask : done
  task tally_and_finish;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1;
    `CHK(pin_oe, '0)
    `CHK(pullup_en, '0)
    `CHK(op_mode, 3'h7)
    done("reset");
    foreach (rows[i]) begin
      apb(1, rows[i][27:16], rows[i][15:8]);
      apb(0, rows[i][27:16], 8'h00);
      `CHK(rdat, rows[i][7:0])
    end
    done("table");
    apb(1, 12'h140, 8'h04);
    #1 `CHK(pin_out[39:32], 8'hC3)
    `CHK(pin_oe[39:32], 8'hFF)
    apb(1, 12'h140, 8'h07);
    done("mode");
    apb(1, 12'h000, 8'hFF);
    apb(1, 12'h040, 8'h3C);
    #1 `CHK(pin_oe[7:0], 8'hFF)
    `CHK(pin_out[7:0], 8'h3C)
    repeat (6) @(posedge clock);
    apb(0, 12'h080, 8'h00);
    `CHK(rdat, 8'h3C)
    done("drive");
    apb(1, 12'h0C0, 8'hFF);
    #1 `CHK(pullup_en[7:0], 8'hFF)
    repeat (6) @(posedge clock);
    apb(0, 12'h090, 8'h00);
    `CHK(rdat, 8'hFF)
    apb(1, 12'h010, 8'h0F);
    #1 `CHK(pullup_en[7:0], 8'hF0)
    apb(1, 12'h050, 8'h05);
    apb(1, 12'h104, 8'hFF);
    #1 `CHK(pin_oe[39:32], 8'h0A)
    apb(1, 12'h008, 8'hFF);
    apb(1, 12'h048, 8'h01);
    #1 `CHK(pin_oe[23:16], 8'hFE)
    done("pull and drain");
    @(posedge clock);
    inonly_in <= 16'hA55A;
    repeat (6) @(posedge clock);
    apb(0, 12'h0B4, 8'h00);
    `CHK(rdat, 8'h5A)
    apb(0, 12'h0B8, 8'h00);
    `CHK(rdat, 8'hA5)
    apb(1, 12'h074, 8'hFF);
    `CHK(rerr, 1'b1)
    apb(1, 12'h034, 8'hFF);
    `CHK(rerr, 1'b1)
    apb(1, 12'h080, 8'hFF);
    `CHK(rerr, 1'b0)
    apb(1, 12'h0D4, 8'hFF);
    `CHK(rerr, 1'b1)
    apb(1, 12'h110, 8'hFF);
    `CHK(rerr, 1'b1)
    pstrb <= 4'h0;
    apb(1, 12'h000, 8'h00);
    pstrb <= 4'hF;
    apb(0, 12'h000, 8'h00);
    `CHK(rdat, 8'hFF)
    done("refusals");
    alt_sel <= 104'h10001;
    alt_out <= 104'h10001;
    alt_oe <= 104'h10001;
    #1 `CHK(pin_out[0], 1'b1)
    `CHK(pin_oe[0], 1'b1)
    `CHK(pin_oe[16], 1'b0)
    @(posedge clock);
    alt_sel <= '0;
    done("alternate");
    rstn <= 0;
    @(posedge clock);
    #1 `CHK(pin_oe, '0)
    `CHK(pullup_en, '0)
    `CHK(op_mode, 3'h7)
    @(posedge clock);
    rstn <= 1;
    apb(0, 12'h140, 8'h00);
    `CHK(rdat, 8'h07)
    done("second reset");
    tally_and_finish();
  end
endmodule : general_purpose_io_ports_test
